// >>> shared/ewf1_pkg.sv
// Constants, encodings and carriers for the extension-word decoder.
// Assumes one clock domain; shared by the decoder and its bench.
package ewf1_pkg;
    // ------------------------------------------------------------
    // Extension word recognition and field layout
    // ------------------------------------------------------------
    localparam logic [15:0] EXT_FIRST = 16'h1800;
    localparam logic [15:0] EXT_LAST = 16'h1fff;
    localparam int EXT_SRC_HI = 10;
    localparam int EXT_SRC_LO = 7;
    localparam int EXT_AL_BIT = 6;
    localparam int EXT_DST_HI = 3;
    localparam int EXT_DST_LO = 0;
    // ------------------------------------------------------------
    // Following instruction word layout
    // ------------------------------------------------------------
    localparam int INS_OP_HI = 15;
    localparam int INS_OP_LO = 12;
    localparam int INS_AD_BIT = 7;
    localparam int INS_BW_BIT = 6;
    localparam int INS_AS_HI = 5;
    localparam int INS_AS_LO = 4;
    localparam int INS_F2_HI = 15;
    localparam int INS_F2_LO = 7;
    localparam logic [8:0] F2_SWAP = 9'h021;
    localparam logic [8:0] F2_SXT = 9'h023;
    localparam logic [3:0] OP_FMT1_MIN = 4'h4;
    localparam logic [3:0] OP_MOVE = 4'h4;
    localparam logic [3:0] OP_ADD = 4'h5;
    localparam logic [3:0] OP_ADDC = 4'h6;
    localparam logic [3:0] OP_SUBC = 4'h7;
    localparam logic [3:0] OP_SUB = 4'h8;
    localparam logic [3:0] OP_CMP = 4'h9;
    localparam logic [3:0] OP_DADD = 4'ha;
    localparam logic [3:0] OP_BIT = 4'hb;
    localparam logic [3:0] OP_BIC = 4'hc;
    localparam logic [3:0] OP_BIS = 4'hd;
    localparam logic [3:0] OP_XOR = 4'he;
    localparam logic [3:0] OP_AND = 4'hf;
    // ------------------------------------------------------------
    // Operand length alignment
    // ------------------------------------------------------------
    localparam int SH_BYTE = 12;
    localparam int SH_WORD = 4;
    localparam int SH_ADDR = 0;
    localparam int NIB_BYTE = 2;
    localparam int NIB_WORD = 4;
    localparam int NIB_ADDR = 5;
    localparam int NIB_ALL = 5;
    localparam logic [4:0] BCD_MAX = 5'h09;
    localparam logic [4:0] BCD_ADJ = 5'h06;
    typedef enum logic [1:0] {
        LEN_BYTE = 2'h0,
        LEN_WORD = 2'h1,
        LEN_ADDR = 2'h2
    } ewf1_len_e;
    typedef enum logic [1:0] {
        CMB_REG_REG = 2'h0,
        CMB_REG_MEM = 2'h1,
        CMB_MEM_REG = 2'h2,
        CMB_MEM_MEM = 2'h3
    } ewf1_combo_e;
    typedef enum logic [1:0] {
        ASM_LO = 2'b01,
        ASM_HI = 2'b10
    } ewf1_asm_e;
    typedef struct packed {
        logic v;
        logic n;
        logic z;
        logic c;
    } ewf1_flags_s;
    typedef struct packed {
        logic valid;
        logic ext;
        logic reserved;
        logic na;
        logic fmt1;
        logic swap;
        logic sxt;
        ewf1_len_e len;
        logic [3:0] op;
        ewf1_combo_e combo;
        logic [3:0] src_hi;
        logic [3:0] dst_hi;
    } ewf1_dec_s;
endpackage : ewf1_pkg

// >>> rtl/ewf1_decoder.sv
// Extension-word decoder and extended two-operand execute unit.
// Assumes fetch, operand and execute strobes are synchronous to mclk_in.
//
// Function
// RULE1: Words 1800h to 1FFFh are extension words modifying the next word.
// RULE2: Extension fields: op-code 15:11, source 10:7, length 6, destination 3:0.
// RULE3: Source nibble forms bits 19:16 of source immediate, index or address.
// RULE4: Destination nibble forms bits 19:16 of destination index or address.
// RULE5: Length bit with byte bit: 01 address, 10 word, 11 byte, 00 reserved.
// RULE6: Swap and sign extend: 00 address, 10 word, byte set not applicable.
// RULE7: All twelve two-operand operations run in extended form.
// RULE8: Subtract gives destination plus inverted source plus one.
// RULE9: Subtract with carry gives destination plus inverted source plus carry.
// RULE10: Add with carry sums binary; decimal add sums the same in BCD.
// RULE11: Arithmetic and compare operations update all four flags.
// RULE12: Move, bit clear and bit set keep all flags.
// RULE13: Bit test, and, xor: carry is not zero; xor overflow from operands.
// RULE14: Four source and destination addressing combinations are recognised.
// RULE15: A 20-bit address in memory is read as two consecutive words.
// RULE16: Compare and bit test update flags only, with no write back.
// RULE17: An extension word applies only to the next instruction word.
//
// Decided for this implementation: strobed fetch, operand, address and execute inputs and their timing.
module ewf1_decoder #(
    parameter int DATA_W = 20
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic fetch_valid_in,
    input wire logic [15:0] fetch_word_in,
    input wire logic opnd_valid_in,
    input wire logic opnd_is_dst_in,
    input wire logic [15:0] opnd_word_in,
    input wire logic mem_addr_valid_in,
    input wire logic [15:0] mem_addr_word_in,
    input wire logic exe_valid_in,
    input wire logic [DATA_W-1:0] exe_src_in,
    input wire logic [DATA_W-1:0] exe_dst_in,
    input wire ewf1_pkg::ewf1_flags_s exe_flags_in,
    output ewf1_pkg::ewf1_dec_s dec_out,
    output logic [DATA_W-1:0] ext_value_out,
    output logic ext_value_valid_out,
    output logic [DATA_W-1:0] mem_addr_out,
    output logic mem_addr_valid_out,
    output logic [DATA_W-1:0] exe_result_out,
    output ewf1_pkg::ewf1_flags_s exe_flags_out,
    output logic exe_write_out,
    output logic exe_done_out
);
    if (DATA_W != 20) begin : g_width_check
        $error("ewf1_decoder serves a 20-bit data path only");
    end
    typedef struct packed {
        logic ext_pend;
        logic [3:0] ext_src;
        logic [3:0] ext_dst;
        logic ext_al;
        ewf1_pkg::ewf1_dec_s dec;
        logic [DATA_W-1:0] xval;
        logic xval_ok;
        ewf1_pkg::ewf1_asm_e asm_st;
        logic [15:0] asm_lo;
        logic [DATA_W-1:0] addr;
        logic addr_ok;
        logic [DATA_W-1:0] result;
        ewf1_pkg::ewf1_flags_s flags;
        logic wr;
        logic done;
    } ewf1_state_s;

    ewf1_state_s s_r;
    ewf1_state_s s_nxt;
    logic is_ext;
    logic [DATA_W+3:0] alu_res;

    // ------------------------------------------------------------
    // Extended two-operand arithmetic
    // ------------------------------------------------------------
    // Operands are left-aligned so bit 19 is always the sign bit
    function automatic logic [DATA_W+3:0] alu_f(
        input logic [3:0] op,
        input ewf1_pkg::ewf1_len_e len,
        input logic [DATA_W-1:0] s,
        input logic [DATA_W-1:0] d,
        input ewf1_pkg::ewf1_flags_s fi
    );
        logic [DATA_W-1:0] sa;
        logic [DATA_W-1:0] da;
        logic [DATA_W-1:0] msk;
        logic [DATA_W-1:0] ra;
        logic [DATA_W-1:0] bcd;
        logic [DATA_W:0] sum;
        logic [4:0] dig;
        logic cy;
        int sh;
        int nib;
        ewf1_pkg::ewf1_flags_s fo;
        sh = (len == ewf1_pkg::LEN_BYTE) ? ewf1_pkg::SH_BYTE :
             (len == ewf1_pkg::LEN_WORD) ? ewf1_pkg::SH_WORD : ewf1_pkg::SH_ADDR;
        nib = (len == ewf1_pkg::LEN_BYTE) ? ewf1_pkg::NIB_BYTE :
              (len == ewf1_pkg::LEN_WORD) ? ewf1_pkg::NIB_WORD : ewf1_pkg::NIB_ADDR;
        sa = s << sh;
        da = d << sh;
        msk = {DATA_W{1'b1}} << sh;
        sum = '0;
        bcd = '0;
        cy = fi.c;
        // Decimal sum nibble by nibble over the operand length
        for (int i = 0; i < ewf1_pkg::NIB_ALL; i++) begin
            if (i < nib) begin
                dig = 5'(s[i*4 +: 4]) + 5'(d[i*4 +: 4]) + 5'(cy);
                if (dig > ewf1_pkg::BCD_MAX) begin
                    dig = dig + ewf1_pkg::BCD_ADJ;
                    cy = 1'b1;
                end else begin
                    cy = 1'b0;
                end
                bcd[i*4 +: 4] = dig[3:0];
            end
        end
        case (op)
            ewf1_pkg::OP_ADD: sum = {1'b0, sa} + {1'b0, da};
            ewf1_pkg::OP_ADDC: sum = {1'b0, sa} + {1'b0, da} + (21'(fi.c) << sh); // [RULE10]
            ewf1_pkg::OP_SUB, ewf1_pkg::OP_CMP: sum = {1'b0, da} + {1'b0, ~sa & msk} + (21'h1 << sh); // [RULE8]
            ewf1_pkg::OP_SUBC: sum = {1'b0, da} + {1'b0, ~sa & msk} + (21'(fi.c) << sh); // [RULE9]
            ewf1_pkg::OP_DADD: sum = {cy, bcd << sh}; // [RULE10]
            ewf1_pkg::OP_BIT, ewf1_pkg::OP_AND: sum = {1'b0, sa & da};
            ewf1_pkg::OP_BIC: sum = {1'b0, ~sa & da};
            ewf1_pkg::OP_BIS: sum = {1'b0, sa | da};
            ewf1_pkg::OP_XOR: sum = {1'b0, sa ^ da};
            default: sum = {1'b0, sa};
        endcase
        ra = sum[DATA_W-1:0];
        fo = fi;
        // Flag effect per operation
        case (op)
            ewf1_pkg::OP_ADD, ewf1_pkg::OP_ADDC, ewf1_pkg::OP_DADD: begin // [RULE11]
                fo.v = (sa[DATA_W-1] == da[DATA_W-1]) && (ra[DATA_W-1] != sa[DATA_W-1]);
                fo.n = ra[DATA_W-1];
                fo.z = (ra == '0);
                fo.c = sum[DATA_W];
            end
            ewf1_pkg::OP_SUB, ewf1_pkg::OP_SUBC, ewf1_pkg::OP_CMP: begin // [RULE11]
                fo.v = (sa[DATA_W-1] != da[DATA_W-1]) && (ra[DATA_W-1] != da[DATA_W-1]);
                fo.n = ra[DATA_W-1];
                fo.z = (ra == '0);
                fo.c = sum[DATA_W];
            end
            ewf1_pkg::OP_BIT, ewf1_pkg::OP_AND, ewf1_pkg::OP_XOR: begin // [RULE13]
                fo.v = (op == ewf1_pkg::OP_XOR) && sa[DATA_W-1] && da[DATA_W-1];
                fo.n = ra[DATA_W-1];
                fo.z = (ra == '0);
                fo.c = (ra != '0);
            end
            default: fo = fi; // [RULE12]
        endcase
        return {ra >> sh, fo};
    endfunction : alu_f

    assign is_ext = (fetch_word_in >= ewf1_pkg::EXT_FIRST) && (fetch_word_in <= ewf1_pkg::EXT_LAST); // [RULE1]
    assign alu_res = alu_f(s_r.dec.op, s_r.dec.len, exe_src_in, exe_dst_in, exe_flags_in);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.dec.valid = 1'b0;
        s_nxt.xval_ok = 1'b0;
        s_nxt.addr_ok = 1'b0;
        s_nxt.done = 1'b0;
        // Fetch: capture extension word or decode the instruction
        if (fetch_valid_in) begin
            if (is_ext) begin
                s_nxt.ext_pend = 1'b1;
                s_nxt.ext_src = fetch_word_in[ewf1_pkg::EXT_SRC_HI:ewf1_pkg::EXT_SRC_LO]; // [RULE2]
                s_nxt.ext_dst = fetch_word_in[ewf1_pkg::EXT_DST_HI:ewf1_pkg::EXT_DST_LO]; // [RULE2]
                s_nxt.ext_al = fetch_word_in[ewf1_pkg::EXT_AL_BIT]; // [RULE2]
            end else begin
                s_nxt.ext_pend = 1'b0; // [RULE17]
                s_nxt.dec.valid = 1'b1;
                s_nxt.dec.ext = s_r.ext_pend;
                s_nxt.dec.op = fetch_word_in[ewf1_pkg::INS_OP_HI:ewf1_pkg::INS_OP_LO];
                s_nxt.dec.fmt1 = s_nxt.dec.op >= ewf1_pkg::OP_FMT1_MIN; // [RULE7]
                s_nxt.dec.swap = fetch_word_in[ewf1_pkg::INS_F2_HI:ewf1_pkg::INS_F2_LO] == ewf1_pkg::F2_SWAP;
                s_nxt.dec.sxt = fetch_word_in[ewf1_pkg::INS_F2_HI:ewf1_pkg::INS_F2_LO] == ewf1_pkg::F2_SXT;
                s_nxt.dec.combo = ewf1_pkg::ewf1_combo_e'({
                    fetch_word_in[ewf1_pkg::INS_AS_HI:ewf1_pkg::INS_AS_LO] != 2'h0,
                    fetch_word_in[ewf1_pkg::INS_AD_BIT]}); // [RULE14]
                s_nxt.dec.src_hi = s_r.ext_pend ? s_r.ext_src : 4'h0;
                s_nxt.dec.dst_hi = s_r.ext_pend ? s_r.ext_dst : 4'h0;
                s_nxt.dec.reserved = 1'b0;
                s_nxt.dec.na = 1'b0;
                // Length from length bit and byte bit
                if (!s_r.ext_pend) begin
                    s_nxt.dec.len = fetch_word_in[ewf1_pkg::INS_BW_BIT] ? ewf1_pkg::LEN_BYTE : ewf1_pkg::LEN_WORD;
                end else if (s_nxt.dec.swap || s_nxt.dec.sxt) begin
                    s_nxt.dec.na = fetch_word_in[ewf1_pkg::INS_BW_BIT]; // [RULE6]
                    s_nxt.dec.len = s_r.ext_al ? ewf1_pkg::LEN_WORD : ewf1_pkg::LEN_ADDR; // [RULE6]
                end else begin
                    case ({s_r.ext_al, fetch_word_in[ewf1_pkg::INS_BW_BIT]}) // [RULE5]
                        2'b01: s_nxt.dec.len = ewf1_pkg::LEN_ADDR;
                        2'b10: s_nxt.dec.len = ewf1_pkg::LEN_WORD;
                        2'b11: s_nxt.dec.len = ewf1_pkg::LEN_BYTE;
                        default: begin
                            s_nxt.dec.len = ewf1_pkg::LEN_WORD;
                            s_nxt.dec.reserved = 1'b1;
                        end
                    endcase
                end
            end
        end
        // Operand word widened by the matching nibble
        if (opnd_valid_in) begin
            s_nxt.xval_ok = 1'b1;
            if (opnd_is_dst_in) begin
                s_nxt.xval = {s_r.dec.dst_hi, opnd_word_in}; // [RULE4]
            end else begin
                s_nxt.xval = {s_r.dec.src_hi, opnd_word_in}; // [RULE3]
            end
        end
        // Memory-held address: low word, then high word
        if (mem_addr_valid_in) begin
            case (s_r.asm_st)
                ewf1_pkg::ASM_LO: begin
                    s_nxt.asm_lo = mem_addr_word_in; // [RULE15]
                    s_nxt.asm_st = ewf1_pkg::ASM_HI;
                end
                ewf1_pkg::ASM_HI: begin
                    s_nxt.addr = {mem_addr_word_in[3:0], s_r.asm_lo}; // [RULE15]
                    s_nxt.addr_ok = 1'b1;
                    s_nxt.asm_st = ewf1_pkg::ASM_LO;
                end
                default: s_nxt.asm_st = ewf1_pkg::ASM_LO;
            endcase
        end
        // Execute the decoded two-operand operation
        if (exe_valid_in) begin
            s_nxt.done = 1'b1;
            if (s_r.dec.fmt1) begin
                s_nxt.result = alu_res[DATA_W+3:4]; // [RULE7]
                s_nxt.flags = alu_res[3:0];
                s_nxt.wr = (s_r.dec.op != ewf1_pkg::OP_CMP) && (s_r.dec.op != ewf1_pkg::OP_BIT); // [RULE16]
            end else begin
                s_nxt.flags = exe_flags_in;
                s_nxt.wr = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            s_r <= '0;
            s_r.asm_st <= ewf1_pkg::ASM_LO;
            s_r.dec.len <= ewf1_pkg::LEN_WORD;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state
    assign dec_out = s_r.dec;
    assign ext_value_out = s_r.xval;
    assign ext_value_valid_out = s_r.xval_ok;
    assign mem_addr_out = s_r.addr;
    assign mem_addr_valid_out = s_r.addr_ok;
    assign exe_result_out = s_r.result;
    assign exe_flags_out = s_r.flags;
    assign exe_write_out = s_r.wr;
    assign exe_done_out = s_r.done;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_ext_range;
        @(posedge mclk_in) disable iff (sys_rst_in)
        fetch_valid_in && is_ext |=> s_r.ext_pend && !dec_out.valid;
    endproperty
    a_ext_range: assert property (p_ext_range) else $error("extension word not held"); // [RULE1]
    property p_ext_fields;
        @(posedge mclk_in) disable iff (sys_rst_in)
        fetch_valid_in && is_ext |=> s_r.ext_src == $past(fetch_word_in[10:7])
            && s_r.ext_dst == $past(fetch_word_in[3:0]) && s_r.ext_al == $past(fetch_word_in[6]);
    endproperty
    a_ext_fields: assert property (p_ext_fields) else $error("extension fields wrong"); // [RULE2]
    property p_ext_once;
        @(posedge mclk_in) disable iff (sys_rst_in)
        fetch_valid_in && !is_ext && s_r.ext_pend |=> dec_out.valid && dec_out.ext && !s_r.ext_pend
            ##1 !(dec_out.valid && dec_out.ext) || s_r.ext_pend;
    endproperty
    a_ext_once: assert property (p_ext_once) else $error("extension applied twice"); // [RULE17]
    property p_len_addr;
        @(posedge mclk_in) disable iff (sys_rst_in)
        fetch_valid_in && !is_ext && s_r.ext_pend && fetch_word_in[15:12] >= 4'h4
            && !s_r.ext_al && fetch_word_in[6] |=> dec_out.len == ewf1_pkg::LEN_ADDR && !dec_out.reserved;
    endproperty
    a_len_addr: assert property (p_len_addr) else $error("address length not chosen"); // [RULE5]
    property p_swap_na;
        @(posedge mclk_in) disable iff (sys_rst_in)
        fetch_valid_in && s_r.ext_pend && fetch_word_in[15:7] == ewf1_pkg::F2_SWAP
            |=> dec_out.na == $past(fetch_word_in[6]);
    endproperty
    a_swap_na: assert property (p_swap_na) else $error("swap length check wrong"); // [RULE6]
    property p_sub_addr;
        @(posedge mclk_in) disable iff (sys_rst_in)
        exe_valid_in && s_r.dec.op == ewf1_pkg::OP_SUB && s_r.dec.len == ewf1_pkg::LEN_ADDR
            |=> exe_result_out == $past(exe_dst_in) - $past(exe_src_in) && exe_write_out;
    endproperty
    a_sub_addr: assert property (p_sub_addr) else $error("subtract result wrong"); // [RULE8]
    property p_flags_kept;
        @(posedge mclk_in) disable iff (sys_rst_in)
        exe_valid_in && (s_r.dec.op == ewf1_pkg::OP_MOVE || s_r.dec.op == ewf1_pkg::OP_BIC
            || s_r.dec.op == ewf1_pkg::OP_BIS) |=> exe_flags_out == $past(exe_flags_in);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed by move"); // [RULE12]
    property p_logic_flags;
        @(posedge mclk_in) disable iff (sys_rst_in)
        exe_valid_in && (s_r.dec.op == ewf1_pkg::OP_BIT || s_r.dec.op == ewf1_pkg::OP_AND)
            |=> !exe_flags_out.v && exe_flags_out.c == !exe_flags_out.z;
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("logic flags wrong"); // [RULE13]
    property p_no_write;
        @(posedge mclk_in) disable iff (sys_rst_in)
        exe_valid_in && (s_r.dec.op == ewf1_pkg::OP_CMP || s_r.dec.op == ewf1_pkg::OP_BIT)
            |=> exe_done_out && !exe_write_out;
    endproperty
    a_no_write: assert property (p_no_write) else $error("compare wrote back"); // [RULE16]
    property p_addr_pair;
        @(posedge mclk_in) disable iff (sys_rst_in)
        mem_addr_valid_in && s_r.asm_st == ewf1_pkg::ASM_HI
            |=> mem_addr_valid_out && mem_addr_out == {$past(mem_addr_word_in[3:0]), $past(s_r.asm_lo)};
    endproperty
    a_addr_pair: assert property (p_addr_pair) else $error("address pair wrong"); // [RULE15]
    property p_src_nib;
        @(posedge mclk_in) disable iff (sys_rst_in)
        opnd_valid_in && !opnd_is_dst_in |=> ext_value_valid_out && ext_value_out[19:16] == $past(s_r.dec.src_hi);
    endproperty
    a_src_nib: assert property (p_src_nib) else $error("source nibble wrong"); // [RULE3]
endmodule : ewf1_decoder

// >>> test/ewf1_fetch_model.sv
// Fetch path model: hands instruction and address words to the decoder.
// Assumes one bench process calls its tasks, one word per clock.
module ewf1_fetch_model (
    input wire logic mclk_in,
    output logic fetch_valid_out,
    output logic [15:0] fetch_word_out,
    output logic mem_valid_out,
    output logic [15:0] mem_word_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet bus at time zero
    initial begin
        fetch_valid_out = 1'b0;
        fetch_word_out = 16'h0000;
        mem_valid_out = 1'b0;
        mem_word_out = 16'h0000;
    end
    // One instruction word
    task automatic fetch(input logic [15:0] w);
        @(posedge mclk_in);
        fetch_valid_out <= 1'b1;
        fetch_word_out <= w;
        mem_valid_out <= 1'b0;
    endtask : fetch
    // One address word, low word first
    task automatic mem(input logic [15:0] w);
        @(posedge mclk_in);
        mem_valid_out <= 1'b1;
        mem_word_out <= w;
        fetch_valid_out <= 1'b0;
    endtask : mem
    // Release: stale words are inverted
    task automatic idle;
        @(posedge mclk_in);
        fetch_valid_out <= 1'b0;
        mem_valid_out <= 1'b0;
        fetch_word_out <= ~fetch_word_out;
        mem_word_out <= ~mem_word_out;
    endtask : idle
endmodule : ewf1_fetch_model

// >>> test/ewf1_decoder_tb.sv
// Self-checking bench for the extension-word decoder.
// Assumes ewf1_pkg, the decoder and the fetch model are compiled first.
module ewf1_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, sys_rst_in, fv, mv, opnd_valid, opnd_is_dst, exe_valid, ext_vv, mem_av, exe_write, exe_done;
    logic [15:0] fw, mw, opnd_word, ins;
    logic [19:0] exe_src, exe_dst, ext_value, mem_addr, exe_result;
    ewf1_pkg::ewf1_flags_s exe_flags, flags_out;
    ewf1_pkg::ewf1_dec_s dec;
    int err_count, cmp_count, i, k, lsel, op, w, s, d, r, f, wr, sn, dn, as, ad, x;
    // ------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    ewf1_fetch_model i_ewf1_fetch_model (.mclk_in(mclk_in), .fetch_valid_out(fv), .fetch_word_out(fw),
        .mem_valid_out(mv), .mem_word_out(mw));
    ewf1_decoder i_ewf1_decoder (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .fetch_valid_in(fv),
        .fetch_word_in(fw), .opnd_valid_in(opnd_valid), .opnd_is_dst_in(opnd_is_dst), .opnd_word_in(opnd_word),
        .mem_addr_valid_in(mv), .mem_addr_word_in(mw), .exe_valid_in(exe_valid), .exe_src_in(exe_src),
        .exe_dst_in(exe_dst), .exe_flags_in(exe_flags), .dec_out(dec), .ext_value_out(ext_value),
        .ext_value_valid_out(ext_vv), .mem_addr_out(mem_addr), .mem_addr_valid_out(mem_av),
        .exe_result_out(exe_result), .exe_flags_out(flags_out), .exe_write_out(exe_write),
        .exe_done_out(exe_done));
    // ------------------------------------------------------------
    // Tasks and reference model
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic go(input logic [15:0] e, input logic [15:0] n, input bit use_e);
        if (use_e) i_ewf1_fetch_model.fetch(e);
        i_ewf1_fetch_model.fetch(n);
        i_ewf1_fetch_model.idle();
        #1;
    endtask : go
    task automatic widen(input logic isd, input logic [15:0] v);
        @(posedge mclk_in);
        opnd_valid <= 1'b1;
        opnd_is_dst <= isd;
        opnd_word <= v;
        @(posedge mclk_in);
        opnd_valid <= 1'b0;
        #1;
    endtask : widen
    task automatic exec(input int a, input int b, input int fl);
        @(posedge mclk_in);
        exe_valid <= 1'b1;
        exe_src <= a[19:0];
        exe_dst <= b[19:0];
        exe_flags <= fl[3:0];
        @(posedge mclk_in);
        exe_valid <= 1'b0;
        #1;
    endtask : exec
    function automatic int bcd(input int v);
        int y;
        y = 0;
        for (int j = 0; j < 5; j++) y = y | ((((v >> 4 * j) & 15) % 10) << 4 * j);
        return y;
    endfunction : bcd
    // Result, flags {v,n,z,c} and write-back of one operation
    function automatic void model(input int op, input int w, input int s, input int d, input int fl,
        output int r, output int f, output int wr);
        int m, t, cy, sb, db, rb, v;
        m = (1 << w) - 1;
        cy = fl & 1;
        t = 0;
        v = 0;
        r = 0;
        case (op)
            4: r = s;
            5: t = s + d;
            6: t = s + d + cy;
            7: t = d + (~s & m) + cy;
            8, 9: t = d + (~s & m) + 1;
            10: for (int j = 0; j < w / 4; j++) begin
                t = ((s >> 4 * j) & 15) + ((d >> 4 * j) & 15) + cy;
                cy = t > 9 ? 1 : 0;
                r = r | ((cy ? t - 10 : t) << 4 * j);
            end
            11, 15: r = s & d;
            12: r = ~s & d & m;
            13: r = s | d;
            default: r = s ^ d;
        endcase
        if (op inside {[5:9]}) begin
            r = t & m;
            cy = (t >> w) & 1;
        end
        sb = (s >> (w - 1)) & 1;
        db = (d >> (w - 1)) & 1;
        rb = (r >> (w - 1)) & 1;
        if (op == 5 || op == 6) v = (sb == db && rb != sb);
        if (op inside {[7:9]}) v = (sb != db && rb != db);
        if (op == 14) v = sb & db;
        if (op inside {11, 14, 15}) cy = (r != 0);
        f = (op inside {4, 12, 13}) ? fl : (v << 3 | rb << 2 | (r == 0) << 1 | cy);
        wr = (op == 9 || op == 11) ? 0 : 1;
    endfunction : model
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {sys_rst_in, opnd_valid, opnd_is_dst, exe_valid} = 4'b1000;
        {opnd_word, exe_src, exe_dst, exe_flags} = '0;
        err_count = 0;
        cmp_count = 0;
        void'($urandom(32'h39b60e4e));
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk({dec.valid, dec.len, exe_done, mem_av, ext_vv}, {1'b0, 2'h1, 3'b000});
        // Every operation at every length
        for (i = 0; i < 36; i++) begin
            op = 4 + i % 12;
            lsel = i / 12;
            w = lsel == 0 ? 20 : (lsel == 1 ? 16 : 8);
            sn = $urandom % 16;
            dn = $urandom % 16;
            as = $urandom % 4;
            ad = $urandom % 2;
            ins = {op[3:0], 4'h5, ad[0], lsel != 1, as[1:0], 4'h6};
            go({5'h03, sn[3:0], lsel != 0, 2'b00, dn[3:0]}, ins, 1);
            chk({dec.valid, dec.ext, dec.reserved, dec.len, dec.op, dec.combo, dec.src_hi, dec.dst_hi},
                {3'b110, 2'(2 - lsel), op[3:0], as != 0, ad[0], sn[3:0], dn[3:0]});
            x = $urandom;
            widen(x[0], x[31:16]);
            chk({ext_vv, ext_value}, {1'b1, x[0] ? dn[3:0] : sn[3:0], x[31:16]});
            s = $urandom & ((1 << w) - 1);
            d = $urandom & ((1 << w) - 1);
            if (op == 10) begin
                s = bcd(s);
                d = bcd(d);
            end
            x = $urandom % 16;
            model(op, w, s, d, x, r, f, wr);
            exec(s, d, x);
            chk({exe_done, exe_write, exe_result}, {1'b1, wr[0], r[19:0]});
            chk(flags_out & (op == 10 ? 4'h7 : 4'hf), f[3:0] & (op == 10 ? 4'h7 : 4'hf));
        end
        $display("test operations done");
        // Extension is used once, reserved length, range top
        go(16'h0000, 16'h5006, 0);
        chk({dec.valid, dec.ext, dec.len, dec.src_hi, dec.dst_hi}, {2'b10, 2'h1, 8'h00});
        go(16'h1800, 16'h5006, 1);
        chk({dec.ext, dec.reserved, dec.len}, {2'b11, 2'h1});
        go(16'h0000, 16'h1fff, 0);
        chk(dec.valid, 1'b0);
        go(16'h0000, 16'h17ff, 0);
        chk({dec.valid, dec.ext, dec.fmt1}, 3'b110);
        exec(1, 2, 5);
        chk({exe_done, exe_write, flags_out}, {2'b10, 4'h5});
        $display("test extension scope done");
        // Swap and sign extend lengths
        for (k = 0; k < 8; k++) begin
            ins = {k[2] ? ewf1_pkg::F2_SXT : ewf1_pkg::F2_SWAP, k[0], 2'b00, 4'h4};
            go({5'h03, 4'h0, k[1], 2'b00, 4'h0}, ins, 1);
            chk({dec.swap, dec.sxt, dec.na}, {~k[2], k[2], k[0]});
            if (!k[0]) chk(dec.len, k[1] ? 2'h1 : 2'h2);
        end
        $display("test swap and sign extend done");
        // Address held in memory, two pairs with an idle cycle between
        for (k = 0; k < 2; k++) begin
            x = $urandom;
            i_ewf1_fetch_model.mem(x[15:0]);
            i_ewf1_fetch_model.mem(x[31:16]);
            i_ewf1_fetch_model.idle();
            #1;
            chk({mem_av, mem_addr}, {1'b1, x[19:16], x[15:0]});
        end
        $display("test memory address done");
        close_out();
    end
endmodule : ewf1_decoder_tb
